// >>> rtl/standard_timer_defs.svh
// register offsets, field positions, reset values and timing counts of the timer
`ifndef STANDARD_TIMER_DEFS_SVH
`define STANDARD_TIMER_DEFS_SVH
`define OFS_CONTROL_ZERO 8'h00
`define OFS_CONTROL_ONE 8'h04
`define OFS_COUNT_LOW 8'h08
`define OFS_COUNT_HIGH 8'h0C
`define OFS_CMPA_LOW 8'h10
`define OFS_CMPA_HIGH 8'h14
`define OFS_STATUS 8'h18
`define OFS_PRESCALE 8'h1C
`define CTL0_ON 3
`define CTL0_P_HI 2
`define CTL0_P_LO 0
`define CTL1_MODE_HI 7
`define CTL1_MODE_LO 6
`define CTL1_PIN_HI 5
`define CTL1_PIN_LO 4
`define CTL1_INIT 3
`define CTL1_INV 2
`define CTL1_SWAP 1
`define CTL1_CLR 0
`define STAT_MATCH_A 0
`define STAT_MATCH_P 1
`define CTL_RESET 8'h00
`define PRESCALE_RESET 8'h00
`define COUNT_MAX 10'h3FF
`define COUNT_ZERO 10'h000
`define P_ZERO 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> rtl/standard_timer_pkg.sv
// types shared by the standard timer
package standard_timer_pkg;
    typedef enum logic [1:0] {
        MODE_COMPARE,
        MODE_CAPTURE,
        MODE_PWM,
        MODE_TIMER
    } mode_e;

    typedef enum logic [1:0] {
        PIN_SEL_0,
        PIN_SEL_1,
        PIN_SEL_2,
        PIN_SEL_3
    } pin_sel_e;

    typedef enum {
        BUS_IDLE,
        BUS_RESP
    } bus_state_e;
endpackage : standard_timer_pkg

// >>> rtl/standard_timer_compare_unit.sv
// standard timer: 10-bit counter, compare A and P, pin output, capture, AXI4-Lite registers
`timescale 1ns/100ps
`include "standard_timer_defs.svh"

module standard_timer_compare_unit (
    input wire logic sysClk, // 200 MHz clock
    input wire logic reset, // asynchronous, active high
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic captureInputPin, // capture pin, synchronous
    output logic timerOutputPin, // timer output pin
    output logic matchFlagIrq // a match flag is set
);
    typedef struct packed {
        standard_timer_pkg::bus_state_e wrState;
        standard_timer_pkg::bus_state_e rdState;
        logic awTaken;
        logic wTaken;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] prescale;
        logic [7:0] preCount;
        logic [9:0] count;
        logic [9:0] cmpA;
        logic [7:0] wrBuf;
        logic [7:0] rdBuf;
        logic matchA;
        logic matchP;
        logic onPrev;
        logic pinLevel;
        logic pinOut;
        logic capPrev;
        logic irq;
        logic awRdy;
        logic wRdy;
        logic arRdy;
        logic bValid;
        logic rValid;
    } state_s;

    state_s s_reg;
    state_s s_next;

    // period in counter units for the 3-bit compare; zero means the full 1024
    function automatic logic [10:0] pPeriod(input logic [2:0] p);
        pPeriod = (p == `P_ZERO) ? 11'h400 : {1'b0, p, 7'h00};
    endfunction : pPeriod

    // byte lane merge for a byte register
    function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
        mergeByte = strb[0] ? d[7:0] : old;
    endfunction : mergeByte

    logic [2:0] pValue;
    logic [1:0] modeSel;
    logic [1:0] pinSel;
    logic timerOn;
    logic initLevel;
    logic invertOut;
    logic swapDuty;
    logic clearOnA;
    logic timerTick;
    logic matchAEvt;
    logic matchPEvt;
    logic overflowEvt;
    logic clearCount;
    logic capEvt;
    logic pwmActive;
    logic [10:0] periodVal;
    logic [10:0] dutyVal;
    logic wrGo;
    logic rdGo;
    logic [31:0] rdValue;
    logic rdOk;
    logic wrOk;

    always_comb begin
        s_next = s_reg;
        pValue = s_reg.ctl0[`CTL0_P_HI:`CTL0_P_LO];
        timerOn = s_reg.ctl0[`CTL0_ON];
        modeSel = s_reg.ctl1[`CTL1_MODE_HI:`CTL1_MODE_LO];
        pinSel = s_reg.ctl1[`CTL1_PIN_HI:`CTL1_PIN_LO];
        initLevel = s_reg.ctl1[`CTL1_INIT];
        invertOut = s_reg.ctl1[`CTL1_INV];
        swapDuty = s_reg.ctl1[`CTL1_SWAP];
        clearOnA = s_reg.ctl1[`CTL1_CLR];

        // timer clock enable from the prescaler; prescale 0 ticks every cycle
        timerTick = 1'b0;
        if (timerOn) begin
            if (s_reg.preCount >= s_reg.prescale) begin
                // no tick in the start cycle, so the residual count cannot match
                timerTick = s_reg.onPrev;
                s_next.preCount = `PRESCALE_RESET;
            end else begin
                s_next.preCount = s_reg.preCount + 8'h01;
            end
        end

        // comparators, evaluated when the counter is about to advance
        matchAEvt = timerTick && (s_reg.cmpA != `COUNT_ZERO)
            && (s_reg.count == s_reg.cmpA);
        matchPEvt = timerTick && (pValue != `P_ZERO)
            && (s_reg.count[9:7] == pValue);
        overflowEvt = timerTick && (s_reg.count == `COUNT_MAX);

        periodVal = pPeriod(pValue);
        dutyVal = {1'b0, s_reg.cmpA};
        if (swapDuty) begin
            periodVal = {1'b0, s_reg.cmpA};
            dutyVal = pPeriod(pValue);
        end

        clearCount = 1'b0;
        capEvt = 1'b0;
        case (modeSel)
            standard_timer_pkg::MODE_COMPARE, standard_timer_pkg::MODE_TIMER: begin
                if (clearOnA) begin
                    clearCount = matchAEvt;
                end else begin
                    clearCount = matchPEvt || (overflowEvt && pValue == `P_ZERO);
                end
                if (matchAEvt) begin
                    s_next.matchA = 1'b1;
                end
                if (matchPEvt && !clearOnA) begin
                    s_next.matchP = 1'b1;
                end
            end
            standard_timer_pkg::MODE_PWM: begin
                // clear_source_select not looked at here
                if (pinSel == standard_timer_pkg::PIN_SEL_3) begin
                    // single pulse: match A ends pulse and switches off
                    if (matchAEvt) begin
                        s_next.matchA = 1'b1;
                        s_next.ctl0[`CTL0_ON] = 1'b0;
                    end
                end else begin
                    clearCount = timerTick && ({1'b0, s_reg.count} + 11'h001 >= periodVal);
                    if (matchAEvt) begin
                        s_next.matchA = 1'b1;
                    end
                    if (matchPEvt) begin
                        s_next.matchP = 1'b1;
                    end
                end
            end
            standard_timer_pkg::MODE_CAPTURE: begin
                clearCount = matchPEvt || (overflowEvt && pValue == `P_ZERO);
                if (matchPEvt) begin
                    s_next.matchP = 1'b1;
                end
                case (pinSel)
                    standard_timer_pkg::PIN_SEL_0: capEvt = captureInputPin && !s_reg.capPrev;
                    standard_timer_pkg::PIN_SEL_1: capEvt = !captureInputPin && s_reg.capPrev;
                    standard_timer_pkg::PIN_SEL_2: capEvt = captureInputPin != s_reg.capPrev;
                    default: capEvt = 1'b0;
                endcase
                capEvt = capEvt && timerOn;
                if (capEvt) begin
                    s_next.cmpA = s_reg.count;
                    s_next.matchA = 1'b1;
                end
            end
            default: clearCount = 1'b0;
        endcase
        s_next.capPrev = captureInputPin;

        // counter: rise of counter_on clears, off holds the residual count
        s_next.onPrev = timerOn;
        if (timerOn && !s_reg.onPrev) begin
            s_next.count = `COUNT_ZERO;
        end else if (clearCount) begin
            s_next.count = `COUNT_ZERO;
        end else if (timerTick) begin
            s_next.count = s_reg.count + 10'h001;
        end

        // output pin level
        pwmActive = ({1'b0, s_reg.count} < dutyVal);
        if (timerOn && !s_reg.onPrev) begin
            s_next.pinLevel = initLevel;
        end else if (modeSel == standard_timer_pkg::MODE_COMPARE && matchAEvt) begin
            case (pinSel)
                standard_timer_pkg::PIN_SEL_1: s_next.pinLevel = 1'b0;
                standard_timer_pkg::PIN_SEL_2: s_next.pinLevel = 1'b1;
                standard_timer_pkg::PIN_SEL_3: s_next.pinLevel = !s_reg.pinLevel;
                default: s_next.pinLevel = s_reg.pinLevel;
            endcase
        end
        case (modeSel)
            standard_timer_pkg::MODE_COMPARE: s_next.pinOut = s_next.pinLevel ^ invertOut;
            standard_timer_pkg::MODE_PWM: begin
                case (pinSel)
                    standard_timer_pkg::PIN_SEL_0: s_next.pinOut = !initLevel ^ invertOut;
                    standard_timer_pkg::PIN_SEL_1: s_next.pinOut = initLevel ^ invertOut;
                    standard_timer_pkg::PIN_SEL_2: s_next.pinOut = ((timerOn && pwmActive)
                        ? initLevel : !initLevel) ^ invertOut;
                    default: s_next.pinOut = ((s_next.ctl0[`CTL0_ON])
                        ? initLevel : !initLevel) ^ invertOut;
                endcase
            end
            default: s_next.pinOut = 1'b0;
        endcase

        // AXI4-Lite write channel: address and data in either order
        wrGo = 1'b0;
        wrOk = 1'b1;
        case (s_reg.wrState)
            standard_timer_pkg::BUS_IDLE: begin
                if (awvalid && !s_reg.awTaken) begin
                    s_next.awTaken = 1'b1;
                    s_next.awAddr = awaddr;
                end
                if (wvalid && !s_reg.wTaken) begin
                    s_next.wTaken = 1'b1;
                    s_next.wData = wdata;
                    s_next.wStrb = wstrb;
                end
                if (s_reg.awTaken && s_reg.wTaken) begin
                    wrGo = 1'b1;
                    s_next.awTaken = 1'b0;
                    s_next.wTaken = 1'b0;
                    s_next.wrState = standard_timer_pkg::BUS_RESP;
                end
            end
            standard_timer_pkg::BUS_RESP: begin
                if (bready) begin
                    s_next.wrState = standard_timer_pkg::BUS_IDLE;
                end
            end
            default: s_next.wrState = standard_timer_pkg::BUS_IDLE;
        endcase
        if (wrGo) begin
            case (s_reg.awAddr)
                `OFS_CONTROL_ZERO: s_next.ctl0 = mergeByte(s_next.ctl0, s_reg.wData, s_reg.wStrb);
                `OFS_CONTROL_ONE: s_next.ctl1 = mergeByte(s_reg.ctl1, s_reg.wData, s_reg.wStrb);
                `OFS_PRESCALE: s_next.prescale = mergeByte(s_reg.prescale, s_reg.wData, s_reg.wStrb);
                `OFS_CMPA_LOW: s_next.wrBuf = mergeByte(s_reg.wrBuf, s_reg.wData, s_reg.wStrb);
                `OFS_CMPA_HIGH: begin
                    if (s_reg.wStrb[0]) begin
                        s_next.cmpA = {s_reg.wData[1:0], s_reg.wrBuf};
                    end
                end
                `OFS_STATUS: begin
                    // write one to clear; a same-cycle match keeps its flag
                    if (s_reg.wStrb[0] && s_reg.wData[`STAT_MATCH_A] && s_next.matchA == s_reg.matchA
                        && !matchAEvt && !capEvt) begin
                        s_next.matchA = 1'b0;
                    end
                    if (s_reg.wStrb[0] && s_reg.wData[`STAT_MATCH_P] && !matchPEvt) begin
                        s_next.matchP = 1'b0;
                    end
                end
                `OFS_COUNT_LOW, `OFS_COUNT_HIGH: wrOk = 1'b0;
                default: wrOk = 1'b0;
            endcase
            s_next.bresp = wrOk ? `RESP_OKAY : `RESP_SLVERR;
        end

        // AXI4-Lite read channel
        rdGo = 1'b0;
        rdOk = 1'b1;
        rdValue = 32'h0000_0000;
        case (araddr)
            `OFS_CONTROL_ZERO: rdValue = {24'h000000, s_reg.ctl0};
            `OFS_CONTROL_ONE: rdValue = {24'h000000, s_reg.ctl1};
            `OFS_PRESCALE: rdValue = {24'h000000, s_reg.prescale};
            `OFS_COUNT_LOW, `OFS_CMPA_LOW: rdValue = {24'h000000, s_reg.rdBuf};
            `OFS_COUNT_HIGH: rdValue = {30'h00000000, s_reg.count[9:8]};
            `OFS_CMPA_HIGH: rdValue = {30'h00000000, s_reg.cmpA[9:8]};
            `OFS_STATUS: rdValue = {30'h00000000, s_reg.matchP, s_reg.matchA};
            default: rdOk = 1'b0;
        endcase
        case (s_reg.rdState)
            standard_timer_pkg::BUS_IDLE: begin
                if (arvalid) begin
                    rdGo = 1'b1;
                    s_next.rdata = rdValue;
                    s_next.rresp = rdOk ? `RESP_OKAY : `RESP_SLVERR;
                    s_next.rdState = standard_timer_pkg::BUS_RESP;
                    if (araddr == `OFS_COUNT_HIGH) begin
                        s_next.rdBuf = s_reg.count[7:0];
                    end else if (araddr == `OFS_CMPA_HIGH) begin
                        s_next.rdBuf = s_reg.cmpA[7:0];
                    end
                end
            end
            standard_timer_pkg::BUS_RESP: begin
                if (rready) begin
                    s_next.rdState = standard_timer_pkg::BUS_IDLE;
                end
            end
            default: s_next.rdState = standard_timer_pkg::BUS_IDLE;
        endcase
        // handshake outputs are registered copies of the next channel state
        s_next.awRdy = (s_next.wrState == standard_timer_pkg::BUS_IDLE) && !s_next.awTaken;
        s_next.wRdy = (s_next.wrState == standard_timer_pkg::BUS_IDLE) && !s_next.wTaken;
        s_next.bValid = (s_next.wrState == standard_timer_pkg::BUS_RESP);
        s_next.arRdy = (s_next.rdState == standard_timer_pkg::BUS_IDLE);
        s_next.rValid = (s_next.rdState == standard_timer_pkg::BUS_RESP);
        s_next.irq = s_next.matchA || s_next.matchP;
    end

    always_ff @(posedge sysClk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.awRdy <= 1'b1;
            s_reg.wRdy <= 1'b1;
            s_reg.arRdy <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bresp = s_reg.bresp;
    assign awready = s_reg.awRdy;
    assign wready = s_reg.wRdy;
    assign arready = s_reg.arRdy;
    assign bvalid = s_reg.bValid;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;
    assign rvalid = s_reg.rValid;
    assign timerOutputPin = s_reg.pinOut;
    assign matchFlagIrq = s_reg.irq;
endmodule : standard_timer_compare_unit

// >>> verif/standard_timer_asserts.sv
// assertions on the timer's register bus and flag output
`timescale 1ns/100ps
module standard_timer_asserts (
    input wire logic sysClk, // clock
    input wire logic reset, // async reset
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    input wire logic awready, // write address ready
    input wire logic wvalid, // write data valid
    input wire logic wready, // write data ready
    input wire logic [1:0] bresp, // write response
    input wire logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    input wire logic arready, // read address ready
    input wire logic [31:0] rdata, // read data
    input wire logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic matchFlagIrq // a match flag is set
);
    default clocking cb @(posedge sysClk);
    endclocking
    default disable iff (reset);
    sequence wrTaken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence rdTaken;
        arvalid && arready;
    endsequence
    a_write_answer: assert property (wrTaken |-> ##2 bvalid)
        else $error("write answer late");
    a_read_answer: assert property (rdTaken |=> rvalid)
        else $error("read answer late");
    a_resp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_count_readonly: assert property (awvalid && awready && (awaddr == 8'h08
        || awaddr == 8'h0C) |-> ##[1:4] (bvalid && bresp == 2'h2))
        else $error("counter write accepted");
    a_high_zero: assert property (rdTaken ##0 (araddr == 8'h0C || araddr == 8'h14)
        |=> rdata[31:2] == 30'h0)
        else $error("high register upper bits set");
    a_low_byte: assert property (rdTaken ##0 (araddr == 8'h08 || araddr == 8'h10)
        |=> rdata[31:8] == 24'h0)
        else $error("low register upper bits set");
    a_flag_sticky: assert property ($fell(matchFlagIrq) |-> bvalid || $past(bvalid))
        else $error("flag cleared without write");
endmodule : standard_timer_asserts
bind standard_timer_compare_unit standard_timer_asserts chk (.sysClk(sysClk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .matchFlagIrq(matchFlagIrq));

// >>> verif/capture_pin_model.sv
// far-side model: drives the capture pin on request
`timescale 1ns/100ps
module capture_pin_model (
    input wire logic sysClk, // timer clock
    input wire logic want, // level asked for by the bench
    output logic pinLevel // level on the capture pin
);
    initial pinLevel = 1'b0;
    always @(posedge sysClk) begin
        pinLevel <= want;
    end
endmodule : capture_pin_model

// >>> verif/standard_timer_compare_unit_test.sv
// self-checking bench for the standard timer
`timescale 1ns/100ps
`include "standard_timer_defs.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin nFail++; \
    $display("wrong value %s exp %0h got %0h", nm, e, s); end end
module standard_timer_compare_unit_test;
    logic sysClk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, capWant = 0, init, inv;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, got;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, resp, pf;
    logic awready, wready, bvalid, arready, rvalid, pinOut, irq, capPin;
    logic [9:0] av, v1, v2;
    int nFail = 0, checks = 0;
    standard_timer_compare_unit dut (.sysClk(sysClk), .reset(reset), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .captureInputPin(capPin), .timerOutputPin(pinOut),
        .matchFlagIrq(irq));
    capture_pin_model far (.sysClk(sysClk), .want(capWant), .pinLevel(capPin));
    initial forever #2.5 sysClk = ~sysClk;
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrapUp
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sysClk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        do begin
            @(posedge sysClk);
            n++;
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
            if (arready && arvalid) arvalid <= 1'b0;
        end while (!(w ? bvalid : rvalid) && n < 200);
        got = rdata;
        resp = w ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
        if (n >= 200) begin
            nFail++;
            wrapUp();
        end
    endtask : bus
    task automatic idle(int c);
        repeat (c) @(posedge sysClk);
    endtask : idle
    task automatic waitIrq(int lim);
        for (int n = 0; n < lim && irq !== 1'b1; n++) @(posedge sysClk);
    endtask : waitIrq
    task automatic rdCnt(output logic [9:0] v);
        bus(0, `OFS_COUNT_HIGH, 0);
        v[9:8] = got[1:0];
        bus(0, `OFS_COUNT_LOW, 0);
        v[7:0] = got[7:0];
    endtask : rdCnt
    task automatic setA(logic [9:0] v);
        bus(1, `OFS_CMPA_LOW, {24'h0, v[7:0]});
        bus(1, `OFS_CMPA_HIGH, {30'h0, v[9:8]});
    endtask : setA
    // stop, program control one, clear flags, then start with the given P value
    task automatic start(logic [7:0] c1, logic [2:0] p);
        bus(1, `OFS_CONTROL_ZERO, {29'h0, p});
        bus(1, `OFS_CONTROL_ONE, {24'h0, c1});
        bus(1, `OFS_STATUS, 32'h3);
        bus(1, `OFS_CONTROL_ZERO, {29'h1, p});
    endtask : start
    function automatic logic lvl(logic [1:0] f, logic i);
        return f == 2'd0 ? i : f == 2'd1 ? 1'b0 : f == 2'd2 ? 1'b1 : !i;
    endfunction : lvl
    initial begin
        void'($urandom(97137));
        idle(5);
        reset <= 1'b0;
        idle(1);
        bus(0, `OFS_CONTROL_ONE, 0);
        `CHK("control one", 32'h0, got)
        bus(0, `OFS_CMPA_HIGH, 0);
        `CHK("compare high", 32'h0, got)
        bus(0, 8'h20, 0);
        `CHK("unmapped", 2'h2, resp)
        bus(1, `OFS_COUNT_LOW, 32'h55);
        `CHK("counter write", 2'h2, resp)
        av = 10'd1 + 10'($urandom % 1023);
        bus(1, `OFS_CMPA_LOW, {24'h0, av[7:0]});
        bus(0, `OFS_CMPA_HIGH, 0);
        bus(0, `OFS_CMPA_LOW, 0);
        `CHK("buffered low", 32'h0, got)
        setA(av);
        bus(0, `OFS_CMPA_HIGH, 0);
        `CHK("compare high", {30'h0, av[9:8]}, got)
        bus(0, `OFS_CMPA_LOW, 0);
        `CHK("compare low", {24'h0, av[7:0]}, got)
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            pf = k[1:0];
            init = k[2];
            inv = 1'($urandom % 2);
            setA(10'd129 + 10'($urandom % 800));
            start({2'b00, pf, init, inv, 2'b01}, 3'd1);
            idle(1);
            `CHK("start level", init ^ inv, pinOut)
            waitIrq(1100);
            `CHK("irq", 1'b1, irq)
            `CHK("match level", lvl(pf, init) ^ inv, pinOut)
            bus(0, `OFS_STATUS, 0);
            `CHK("only flag a", 2'b01, got[1:0])
        end
        $display("test compare clear on a done");
        setA(10'd60);
        start(8'h00, 3'd1);
        idle(140);
        bus(0, `OFS_STATUS, 0);
        `CHK("both flags", 2'b11, got[1:0])
        idle(10'($urandom % 300));
        rdCnt(v1);
        `CHK("period bound", 1'b0, v1 >= 10'd129)
        bus(1, `OFS_CONTROL_ZERO, 32'h1);
        rdCnt(v1);
        idle(50);
        rdCnt(v2);
        `CHK("held count", v1, v2)
        bus(1, `OFS_CONTROL_ZERO, 32'h9);
        rdCnt(v2);
        `CHK("restart clear", 1'b1, v2 < 10'd20)
        $display("test clear on p done");
        start(8'hC0, 3'd0);
        setA(10'd0);
        idle(1100);
        bus(0, `OFS_STATUS, 0);
        `CHK("no flag a", 1'b0, got[0])
        $display("test zero compare done");
        for (int k = 0; k < 4; k++) begin
            pf = k[1:0];
            start({2'b01, pf, 4'h0}, 3'd1);
            capWant <= 1'b1;
            idle(4);
            bus(0, `OFS_STATUS, 0);
            `CHK("capture rise", pf == 2'd0 || pf == 2'd2, got[0])
            bus(1, `OFS_STATUS, 32'h3);
            capWant <= 1'b0;
            idle(4);
            bus(0, `OFS_STATUS, 0);
            `CHK("capture fall", pf == 2'd1 || pf == 2'd2, got[0])
        end
        $display("test capture done");
        for (int k = 0; k < 8; k++) begin
            start({2'b10, 1'b0, k[0], k[1], k[2], 2'b01}, 3'd1);
            idle(2);
            `CHK("forced level", (k[0] ? k[1] : !k[1]) ^ k[2], pinOut)
        end
        $display("test forced output done");
        av = 10'd16 + 10'($urandom % 100);
        setA(av);
        start(8'hA8, 3'd1);
        idle(4);
        v1 = 10'd0;
        repeat (256) begin
            @(posedge sysClk);
            v1 = v1 + 10'(pinOut);
        end
        `CHK("pwm duty", av + av, v1)
        start(8'hB8, 3'd1);
        idle(2);
        `CHK("pulse high", 1'b1, pinOut)
        idle(int'(av) + 10);
        bus(0, `OFS_CONTROL_ZERO, 0);
        `CHK("pulse end", 2'b00, {got[3], pinOut})
        $display("test pwm and pulse done");
        wrapUp();
    end
    initial begin
        repeat (90000) @(posedge sysClk);
        nFail++;
        wrapUp();
    end
endmodule : standard_timer_compare_unit_test
